// [ofd_cfg.svh]
// Field positions, register offsets and reset values for the opcode field decoder
`ifndef OFD_CFG_SVH
`define OFD_CFG_SVH
`define OFD_INSTR_W 48
`define OFD_ADDR_W 32
`define OFD_BUS_AW 4
`define OFD_BUS_DW 48
`define OFD_NARROW_W 16
`define OFD_WIDE_W 32
`define OFD_MF_BIT 47
`define OFD_POP_BIT 46
`define OFD_PUSH_BIT 45
`define OFD_UPD_BIT 44
`define OFD_RN_HI 15
`define OFD_RN_LO 12
`define OFD_RX_HI 11
`define OFD_RX_LO 8
`define OFD_RY_HI 7
`define OFD_RY_LO 4
`define OFD_AX_HI 7
`define OFD_AX_LO 6
`define OFD_AY_HI 5
`define OFD_AY_LO 4
`define OFD_MX_HI 3
`define OFD_MX_LO 2
`define OFD_MY_HI 1
`define OFD_MY_LO 0
`define OFD_BASE_ALU_X 4'h8
`define OFD_BASE_ALU_Y 4'hC
`define OFD_BASE_MULT_X 4'h0
`define OFD_BASE_MULT_Y 4'h4
`define OFD_REG_CTRL 4'h0
`define OFD_REG_STATUS 4'h1
`define OFD_REG_NARROW 4'h2
`define OFD_REG_WIDE 4'h3
`define OFD_REG_WHOLE 4'h4
`define OFD_CTRL_EN_BIT 0
`define OFD_CTRL_RESET 1'h1
`define OFD_ZERO_RF 4'h0
`define OFD_ZERO_ADDR 32'h0
`define OFD_ZERO_BUS 48'h0
`define OFD_ZERO_NARROW 16'h0
`define OFD_ZERO_WIDE 32'h0
`endif

// [ofd_pkg.sv]
// Shared types of the opcode field decoder
package ofd_pkg;
	typedef logic [3:0] ofd_rf_idx_t;
	typedef logic [1:0] ofd_bank_off_t;
endpackage

// [ofd_exchange.sv]
// Bus exchange register: narrow and wide halves and their 48-bit union
`timescale 1ns/1ps
`include "ofd_cfg.svh"
module ofd_exchange (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Write side
	input wire logic i_wr_narrow,
	input wire logic i_wr_wide,
	input wire logic i_wr_whole,
	input wire logic [`OFD_BUS_DW-1:0] i_wdata,
	// Held values
	output logic [`OFD_NARROW_W-1:0] o_exchange_narrow,
	output logic [`OFD_WIDE_W-1:0] o_exchange_wide
);
	// Whole write moves both halves in the same edge, so no half-updated union is seen
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_exchange_narrow <= `OFD_ZERO_NARROW;
		end else if (i_wr_whole) begin
			o_exchange_narrow <= i_wdata[`OFD_NARROW_W-1:0];
		end else if (i_wr_narrow) begin
			o_exchange_narrow <= i_wdata[`OFD_NARROW_W-1:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_exchange_wide <= `OFD_ZERO_WIDE;
		end else if (i_wr_whole) begin
			o_exchange_wide <= i_wdata[`OFD_BUS_DW-1:`OFD_NARROW_W];
		end else if (i_wr_wide) begin
			o_exchange_wide <= i_wdata[`OFD_WIDE_W-1:0];
		end
	end
endmodule

// [ofd_decoder.sv]
// Opcode field decoder for stack codes, index update, operand selectors and exchange register
// Summary of operation
// - Pop bit one pops status stack
// - Push bit one pushes current status
// - Update bit chooses pre-modify without writeback or post-modify with writeback
// - General selectors address register file 0-15
// - Multifunction ALU operands banks 8-11, 12-15
// - Multifunction multiplier operands banks 0-3, 4-7
// - 48-bit exchange joins 16-bit and 32-bit halves
// - Unassigned opcode bits never affect decode
`timescale 1ns/1ps
`include "ofd_cfg.svh"
module ofd_decoder (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Instruction from the sequencer
	input wire logic i_instr_vld,
	input wire logic [`OFD_INSTR_W-1:0] i_instr,
	input wire logic [`OFD_ADDR_W-1:0] i_index,
	input wire logic [`OFD_ADDR_W-1:0] i_modify,
	// Register port
	input wire logic [`OFD_BUS_AW-1:0] i_addr,
	input wire logic [`OFD_BUS_DW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [`OFD_BUS_DW-1:0] o_rdata,
	// Decoded controls
	output logic o_dec_vld,
	output logic o_multifunc,
	output logic o_status_stack_pop,
	output logic o_status_stack_push,
	output logic [`OFD_ADDR_W-1:0] o_mem_addr,
	output logic o_index_wr,
	output logic [`OFD_ADDR_W-1:0] o_index_wdata,
	// Operand selectors
	output ofd_pkg::ofd_rf_idx_t o_compute_reg_sel_n,
	output ofd_pkg::ofd_rf_idx_t o_compute_reg_sel_x,
	output ofd_pkg::ofd_rf_idx_t o_compute_reg_sel_y,
	output ofd_pkg::ofd_rf_idx_t o_alu_x_operand_sel,
	output ofd_pkg::ofd_rf_idx_t o_alu_y_operand_sel,
	output ofd_pkg::ofd_rf_idx_t o_mult_x_operand_sel,
	output ofd_pkg::ofd_rf_idx_t o_mult_y_operand_sel
);
	logic ctrl_en_r;
	logic take;
	logic mf;
	logic upd;
	logic [`OFD_ADDR_W-1:0] sum;
	logic [`OFD_NARROW_W-1:0] ex_narrow;
	logic [`OFD_WIDE_W-1:0] ex_wide;
	logic wr_narrow;
	logic wr_wide;
	logic wr_whole;
	logic [`OFD_BUS_DW-1:0] rdata_nxt;

	// Bank base plus offset; base low bits are zero so the add never carries out
	function automatic ofd_pkg::ofd_rf_idx_t bank_index(input ofd_pkg::ofd_rf_idx_t base,
		input ofd_pkg::ofd_bank_off_t off);
		bank_index = base + {2'h0, off};
	endfunction

	// Only the listed fields are read; every other opcode bit is left unconnected
	assign take = i_instr_vld & ctrl_en_r;
	assign mf = i_instr[`OFD_MF_BIT];
	assign upd = i_instr[`OFD_UPD_BIT];
	assign sum = i_index + i_modify;

	assign wr_narrow = i_wr & (i_addr == `OFD_REG_NARROW);
	assign wr_wide = i_wr & (i_addr == `OFD_REG_WIDE);
	assign wr_whole = i_wr & (i_addr == `OFD_REG_WHOLE);

	ofd_exchange u_exchange (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_wr_narrow(wr_narrow),
		.i_wr_wide(wr_wide),
		.i_wr_whole(wr_whole),
		.i_wdata(i_wdata),
		.o_exchange_narrow(ex_narrow),
		.o_exchange_wide(ex_wide)
	);

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			ctrl_en_r <= `OFD_CTRL_RESET;
		end else if (i_wr && i_addr == `OFD_REG_CTRL) begin
			ctrl_en_r <= i_wdata[`OFD_CTRL_EN_BIT];
		end
	end

	// Valid and stack strobes are one-cycle pulses per accepted instruction
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_dec_vld <= 1'b0;
		end else begin
			o_dec_vld <= take;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_status_stack_pop <= 1'b0;
		end else begin
			o_status_stack_pop <= take & i_instr[`OFD_POP_BIT];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_status_stack_push <= 1'b0;
		end else begin
			o_status_stack_push <= take & i_instr[`OFD_PUSH_BIT];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_index_wr <= 1'b0;
		end else begin
			o_index_wr <= take & upd;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_mem_addr <= `OFD_ZERO_ADDR;
		end else if (take) begin
			o_mem_addr <= upd ? i_index : sum;
		end
	end

	// Write-back value is only meaningful while o_index_wr pulses
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_index_wdata <= `OFD_ZERO_ADDR;
		end else if (take) begin
			o_index_wdata <= upd ? sum : i_index;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_multifunc <= 1'b0;
		end else if (take) begin
			o_multifunc <= mf;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_compute_reg_sel_n <= `OFD_ZERO_RF;
		end else if (take) begin
			o_compute_reg_sel_n <= i_instr[`OFD_RN_HI:`OFD_RN_LO];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_compute_reg_sel_x <= `OFD_ZERO_RF;
		end else if (take) begin
			o_compute_reg_sel_x <= i_instr[`OFD_RX_HI:`OFD_RX_LO];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_compute_reg_sel_y <= `OFD_ZERO_RF;
		end else if (take) begin
			o_compute_reg_sel_y <= i_instr[`OFD_RY_HI:`OFD_RY_LO];
		end
	end

	// Restricted banks are driven even outside multifunction; consumers qualify with o_multifunc
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_alu_x_operand_sel <= `OFD_BASE_ALU_X;
		end else if (take) begin
			o_alu_x_operand_sel <= bank_index(`OFD_BASE_ALU_X, i_instr[`OFD_AX_HI:`OFD_AX_LO]);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_alu_y_operand_sel <= `OFD_BASE_ALU_Y;
		end else if (take) begin
			o_alu_y_operand_sel <= bank_index(`OFD_BASE_ALU_Y, i_instr[`OFD_AY_HI:`OFD_AY_LO]);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_mult_x_operand_sel <= `OFD_BASE_MULT_X;
		end else if (take) begin
			o_mult_x_operand_sel <= bank_index(`OFD_BASE_MULT_X, i_instr[`OFD_MX_HI:`OFD_MX_LO]);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_mult_y_operand_sel <= `OFD_BASE_MULT_Y;
		end else if (take) begin
			o_mult_y_operand_sel <= bank_index(`OFD_BASE_MULT_Y, i_instr[`OFD_MY_HI:`OFD_MY_LO]);
		end
	end

	always_comb begin
		rdata_nxt = `OFD_ZERO_BUS;
		unique case (i_addr)
			`OFD_REG_CTRL: rdata_nxt[`OFD_CTRL_EN_BIT] = ctrl_en_r;
			`OFD_REG_STATUS: rdata_nxt = {o_dec_vld, o_multifunc, o_status_stack_pop, o_status_stack_push,
				o_index_wr, 31'h0, o_compute_reg_sel_n, o_compute_reg_sel_x, o_compute_reg_sel_y};
			`OFD_REG_NARROW: rdata_nxt = {32'h0, ex_narrow};
			`OFD_REG_WIDE: rdata_nxt = {16'h0, ex_wide};
			`OFD_REG_WHOLE: rdata_nxt = {ex_wide, ex_narrow};
			default: rdata_nxt = `OFD_ZERO_BUS;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_rdata <= `OFD_ZERO_BUS;
		end else if (i_rd) begin
			o_rdata <= rdata_nxt;
		end else begin
			o_rdata <= `OFD_ZERO_BUS;
		end
	end
endmodule

// [ofd_sva.sv]
// Checker for the opcode field decoder ports
`timescale 1ns/1ps
module ofd_sva (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Observed inputs
	input wire logic [47:0] i_instr,
	input wire logic [31:0] i_index,
	input wire logic [31:0] i_modify,
	input wire logic i_rd,
	// Observed outputs
	input wire logic o_dec_vld,
	input wire logic o_status_stack_pop,
	input wire logic o_status_stack_push,
	input wire logic o_index_wr,
	input wire logic [31:0] o_mem_addr,
	input wire logic [47:0] o_rdata,
	input wire ofd_pkg::ofd_rf_idx_t o_alu_x_operand_sel,
	input wire ofd_pkg::ofd_rf_idx_t o_mult_y_operand_sel
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// Pulses are tied to the decode strobe so a stray pulse is caught too
	chk_pop_code: assert property ((o_dec_vld || o_status_stack_pop)
		|-> o_dec_vld && o_status_stack_pop == $past(i_instr[46]))
		else $error("pop pulse mismatch");
	chk_push_code: assert property ((o_dec_vld || o_status_stack_push)
		|-> o_dec_vld && o_status_stack_push == $past(i_instr[45]))
		else $error("push pulse mismatch");
	chk_idx_code: assert property ((o_dec_vld || o_index_wr)
		|-> o_dec_vld && o_index_wr == $past(i_instr[44]))
		else $error("index write pulse mismatch");
	chk_upd_pre: assert property (o_dec_vld && !o_index_wr |-> o_mem_addr == $past(i_index) + $past(i_modify))
		else $error("pre-modify address mismatch");
	chk_upd_post: assert property (o_dec_vld && o_index_wr |-> o_mem_addr == $past(i_index))
		else $error("post-modify address mismatch");
	chk_alu_bank: assert property (o_dec_vld |-> o_alu_x_operand_sel == {2'b10, $past(i_instr[7:6])})
		else $error("alu x bank mismatch");
	chk_mult_bank: assert property (o_dec_vld |-> o_mult_y_operand_sel == {2'b01, $past(i_instr[1:0])})
		else $error("mult y bank mismatch");
	chk_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 48'h0)
		else $error("read data outside read slot");
	cov_pop: cover property (o_status_stack_pop && o_status_stack_push);
	cov_post: cover property (o_index_wr);
	cov_pre: cover property (o_dec_vld && !o_index_wr);
endmodule
bind ofd_decoder ofd_sva u_sva (.*);

// [ofd_seq_model.sv]
// Sequencer model feeding instruction words
`timescale 1ns/1ps
module ofd_seq_model (
	// Clock
	input wire logic i_clk,
	// Instruction out
	output logic o_vld,
	output logic [47:0] o_instr,
	output logic [31:0] o_index,
	output logic [31:0] o_modify
);
	initial {o_vld, o_instr, o_index, o_modify} = '0;
	// Idle cycles scramble the word so stale data is never mistaken for a fetch
	task send(input logic [47:0] w, input logic [31:0] ix, md, input int gap);
		o_vld <= 1'b1;
		o_instr <= w;
		o_index <= ix;
		o_modify <= md;
		@(posedge i_clk);
		repeat (gap) begin
			o_vld <= 1'b0;
			o_instr <= ~o_instr;
			o_index <= ~o_index;
			@(posedge i_clk);
		end
	endtask
endmodule

// [ofd_decoder_bench.sv]
// Self-checking bench for the opcode field decoder
`timescale 1ns/1ps
module ofd_decoder_bench;
	logic i_clk = 1'b0;
	logic rd_p = 1'b0;
	logic i_rst_b, i_instr_vld, i_wr, i_rd, o_dec_vld, o_multifunc, o_status_stack_pop;
	logic o_status_stack_push, o_index_wr, en;
	logic [95:0] got_w;
	logic [47:0] i_instr, i_wdata, o_rdata, w;
	logic [31:0] i_index, i_modify, o_mem_addr, o_index_wdata;
	logic [3:0] i_addr;
	ofd_pkg::ofd_rf_idx_t o_compute_reg_sel_n, o_compute_reg_sel_x, o_compute_reg_sel_y, o_alu_x_operand_sel;
	ofd_pkg::ofd_rf_idx_t o_alu_y_operand_sel, o_mult_x_operand_sel, o_mult_y_operand_sel;
	logic [95:0] dq[$];
	logic [47:0] rq[$];
	int err_count, total_checks, seed;
	ofd_decoder dut (.*);
	ofd_seq_model u_seq (.i_clk, .o_vld(i_instr_vld), .o_instr(i_instr), .o_index(i_index), .o_modify(i_modify));
	always #50 i_clk = ~i_clk;
	task check(input logic [95:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task final_report;
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Two draws cut to one instruction word on purpose
	function automatic logic [47:0] rnd48();
		logic [63:0] r;
		r = {$random(seed), $random(seed)};
		return r[47:0];
	endfunction
	function automatic logic [95:0] dexp(input logic [47:0] d, input logic [31:0] ix, md);
		return {d[46:44], d[47], d[44] ? ix : ix + md, d[44] ? ix + md : ix, d[15:4],
			2'b10, d[7:6], 2'b11, d[5:4], 2'b00, d[3:2], 2'b01, d[1:0]};
	endfunction
	task bus(input logic w_, r_, input logic [3:0] a, input logic [47:0] d);
		i_wr <= w_;
		i_rd <= r_;
		i_addr <= a;
		i_wdata <= d;
		if (r_) rq.push_back(d);
		@(posedge i_clk);
	endtask
	task ins(input logic [47:0] d, input int gap);
		logic [31:0] ix, md;
		ix = $random(seed);
		md = $random(seed);
		if (en) dq.push_back(dexp(d, ix, md));
		u_seq.send(d, ix, md, gap);
	endtask
	always @(negedge i_clk) begin
		if (o_dec_vld === 1'b1) begin
			got_w = {o_status_stack_pop, o_status_stack_push, o_index_wr, o_multifunc, o_mem_addr,
				o_index_wdata, o_compute_reg_sel_n, o_compute_reg_sel_x, o_compute_reg_sel_y, o_alu_x_operand_sel,
				o_alu_y_operand_sel, o_mult_x_operand_sel, o_mult_y_operand_sel};
			check(got_w, dq.size() ? dq.pop_front() : '1);
		end
		if (rd_p) check(o_rdata, rq.pop_front());
		rd_p = i_rd;
	end
	// Budget of 10000 cycles is far above the under 250 cycles the sequence needs
	initial begin
		#1000000;
		err_count++;
		final_report;
	end
	initial begin
		seed = 52100;
		{i_rst_b, i_wr, i_rd, i_addr, i_wdata} = '0;
		en = 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst_b <= 1'b1;
		bus(0, 1, 4'h0, 48'h1);
		for (int a = 1; a < 5; a++) bus(0, 1, a[3:0], 48'h0);
		w = rnd48();
		bus(1, 0, 4'h4, w);
		bus(0, 1, 4'h2, {32'h0, w[15:0]});
		bus(0, 1, 4'h3, {16'h0, w[47:16]});
		bus(1, 0, 4'h2, ~w);
		bus(1, 0, 4'hF, w);
		bus(0, 1, 4'h4, {w[47:16], ~w[15:0]});
		bus(0, 1, 4'hE, 48'h0);
		bus(1, 0, 4'h3, w);
		bus(0, 1, 4'h4, {w[31:0], ~w[15:0]});
		bus(0, 0, 4'h0, 48'h0);
		// Random words also flip every unassigned opcode bit
		ins(48'hFFFF_FFFF_FFFF, 0);
		ins(48'h0, 0);
		for (int i = 0; i < 60; i++) ins(rnd48(), ($random(seed) & 3) == 0 ? 2 : 0);
		ins(48'h7FFF_0000_1234, 1);
		// Multifunction level and selector fields stay readable after the pulses end
		ins(48'h8000_0000_0456, 1);
		bus(0, 1, 4'h1, 48'h4000_0000_0045);
		bus(1, 0, 4'h0, 48'h0);
		bus(0, 1, 4'h0, 48'h0);
		bus(0, 0, 4'h0, 48'h0);
		en = 1'b0;
		for (int i = 0; i < 4; i++) ins(rnd48(), i / 3);
		bus(1, 0, 4'h0, 48'h1);
		bus(0, 0, 4'h0, 48'h0);
		en = 1'b1;
		ins(48'h2000_0000_ABCD, 0);
		ins(48'h4000_0000_5A5A, 2);
		// Mid-run reset with decode disabled: enable and bank bases must come back
		bus(1, 0, 4'h0, 48'h0);
		i_rst_b <= 1'b0;
		bus(0, 0, 4'h0, 48'h0);
		bus(0, 0, 4'h0, 48'h0);
		i_rst_b <= 1'b1;
		@(negedge i_clk);
		check({o_alu_x_operand_sel, o_alu_y_operand_sel, o_mult_x_operand_sel, o_mult_y_operand_sel}, 16'h8C04);
		check({o_dec_vld, o_status_stack_pop, o_status_stack_push, o_index_wr, o_mem_addr}, 36'h0);
		@(posedge i_clk);
		bus(0, 1, 4'h0, 48'h1);
		bus(0, 0, 4'h0, 48'h0);
		check(dq.size() + rq.size(), 0);
		final_report;
	end
endmodule
